/* core/pif_pkg.sv */
// package for the prioritized interrupt flag block
package pif_pkg;
    // register addresses
    localparam logic [15:0] ADDR_FLAGS_LOW = 16'hFFE0;
    localparam logic [15:0] ADDR_FLAGS_HIGH = 16'hFFE1;
    localparam logic [15:0] ADDR_MASK_LOW = 16'hFFE4;
    localparam logic [15:0] ADDR_MASK_HIGH = 16'hFFE5;
    localparam logic [15:0] ADDR_CONTROL = 16'hFFE8;
    localparam logic [15:0] ADDR_STATUS = 16'hFFE9;
    // reset values
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'hFF;
    // implemented bits of the two register pairs
    localparam logic [7:0] LOW_USED = 8'h7F;
    localparam logic [7:0] HIGH_USED = 8'h81;
    // control register fields
    localparam int CTRL_BIT_IE = 0;
    localparam int CTRL_BIT_WDM1 = 1;
    // number of maskable request lines
    localparam int NUM_REQ = 9;
    // vector table addresses
    localparam logic [15:0] VEC_NMI = 16'h0004;
    localparam logic [15:0] VEC_WDT = 16'h0004;
    localparam logic [15:0] VEC_PIN0 = 16'h0006;
    localparam logic [15:0] VEC_PIN1 = 16'h0008;
    localparam logic [15:0] VEC_PIN2 = 16'h000A;
    localparam logic [15:0] VEC_SRX = 16'h000C;
    localparam logic [15:0] VEC_STX = 16'h000E;
    localparam logic [15:0] VEC_TM8 = 16'h0010;
    localparam logic [15:0] VEC_TM16 = 16'h0014;
    localparam logic [15:0] VEC_KEY = 16'h002A;
    // acknowledge sequence states
    typedef enum logic [3:0] {
        PIF_IDLE = 4'h1,
        PIF_PUSH_PSW = 4'h2,
        PIF_PUSH_PC = 4'h4,
        PIF_VECTOR = 4'h8
    } pif_state_t;
    // request presented to the core
    typedef struct packed {
        logic valid;
        logic nmi;
        logic [3:0] level;
        logic [15:0] vector;
    } pif_req_t;
endpackage

/* core/pif_top.sv */
// prioritized interrupt flags, arbiter and acknowledge sequencer
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
module pif_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic watchdog_overflow_request_i,
    input wire logic watchdog_mode1_i,
    input wire logic pin_edge_request_0_i,
    input wire logic pin_edge_request_1_i,
    input wire logic pin_edge_request_2_i,
    input wire logic serial_receive_done_request_i,
    input wire logic three_wire_done_request_i,
    input wire logic serial_transmit_done_request_i,
    input wire logic byte_timer_match_request_i,
    input wire logic word_timer_match_request_i,
    input wire logic key_return_request_i,
    input wire logic [15:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic ack_i,
    output pif_pkg::pif_req_t req_o,
    output logic standby_release_o,
    output logic push_psw_o,
    output logic push_pc_o,
    output logic load_pc_o,
    output logic [15:0] vector_o,
    output logic global_interrupt_enable_o
);
    // one sync lane per event input, watchdog overflow in lane 0
    localparam int NREQ_W = 10;
    logic [1:0] mode_sync_q;
    logic [NREQ_W-1:0] ev_s1_q;
    logic [NREQ_W-1:0] ev_s2_q;
    logic [NREQ_W-1:0] ev_prev_q;
    logic [NREQ_W-1:0] ev_rise;
    logic nmi_pend_q;
    logic [7:0] flags_low_q;
    logic [7:0] flags_high_q;
    logic [7:0] mask_low_q;
    logic [7:0] mask_high_q;
    logic ie_q;
    logic [pif_pkg::NUM_REQ-1:0] flag_vec;
    logic [pif_pkg::NUM_REQ-1:0] mask_vec;
    logic [pif_pkg::NUM_REQ-1:0] ready_vec;
    logic [pif_pkg::NUM_REQ-1:0] set_vec;
    logic [pif_pkg::NUM_REQ-1:0] clr_vec;
    logic [3:0] win_idx;
    logic win_valid;
    logic [15:0] win_vec;
    pif_pkg::pif_state_t state_q;
    pif_pkg::pif_req_t taken_q;
    logic wr_low;
    logic wr_high;
    logic wr_ctrl;
    logic [7:0] rd_d;

    // two-stage sync on all asynchronous event lines and the mode strap
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ev_s1_q <= '0;
            ev_s2_q <= '0;
            ev_prev_q <= '0;
            mode_sync_q <= 2'h0;
        end else begin
            ev_s1_q <= {key_return_request_i, word_timer_match_request_i,
                byte_timer_match_request_i, serial_transmit_done_request_i,
                three_wire_done_request_i, serial_receive_done_request_i,
                pin_edge_request_2_i, pin_edge_request_1_i, pin_edge_request_0_i,
                watchdog_overflow_request_i};
            ev_s2_q <= ev_s1_q;
            ev_prev_q <= ev_s2_q;
            mode_sync_q <= {mode_sync_q[0], watchdog_mode1_i};
        end
    end
    // events are pulses; rising edge marks one occurrence
    assign ev_rise = ev_s2_q & ~ev_prev_q;

    // line index = priority; receive and three-wire merge into one line
    always_comb begin
        set_vec = '0;
        set_vec[0] = ev_rise[0] & ~mode_sync_q[1];
        set_vec[1] = ev_rise[1];
        set_vec[2] = ev_rise[2];
        set_vec[3] = ev_rise[3];
        set_vec[4] = ev_rise[4] | ev_rise[5];
        set_vec[5] = ev_rise[6];
        set_vec[6] = ev_rise[7];
        set_vec[7] = ev_rise[8];
        set_vec[8] = ev_rise[9];
    end

    // map flag and mask bits onto priority-ordered lines
    assign flag_vec = {flags_high_q[0], flags_high_q[7], flags_low_q[6:0]};
    assign mask_vec = {mask_high_q[0], mask_high_q[7], mask_low_q[6:0]};
    // lines that would be served if the global enable allowed it
    assign ready_vec = flag_vec & ~mask_vec;

    // fixed priority pick, lowest index wins
    always_comb begin
        win_idx = 4'h0;
        win_valid = 1'b0;
        for (int i = pif_pkg::NUM_REQ - 1; i >= 0; i--) begin
            if (flag_vec[i] && !mask_vec[i]) begin
                win_idx = 4'(i);
                win_valid = 1'b1;
            end
        end
    end

    // vector table lookup
    always_comb begin
        case (win_idx)
            4'h0: win_vec = pif_pkg::VEC_WDT;
            4'h1: win_vec = pif_pkg::VEC_PIN0;
            4'h2: win_vec = pif_pkg::VEC_PIN1;
            4'h3: win_vec = pif_pkg::VEC_PIN2;
            4'h4: win_vec = pif_pkg::VEC_SRX;
            4'h5: win_vec = pif_pkg::VEC_STX;
            4'h6: win_vec = pif_pkg::VEC_TM8;
            4'h7: win_vec = pif_pkg::VEC_TM16;
            default: win_vec = pif_pkg::VEC_KEY;
        endcase
    end

    // address decode
    assign wr_low = wr_i && (addr_i == pif_pkg::ADDR_FLAGS_LOW);
    assign wr_high = wr_i && (addr_i == pif_pkg::ADDR_FLAGS_HIGH);
    assign wr_ctrl = wr_i && (addr_i == pif_pkg::ADDR_CONTROL);

    // acknowledge of a maskable request clears its flag
    always_comb begin
        clr_vec = '0;
        if (state_q == pif_pkg::PIF_IDLE && ack_i && taken_q.valid && !taken_q.nmi) begin
            clr_vec[taken_q.level] = 1'b1;
        end
    end

    // request flags: set beats acknowledge clear and write; write overrides the clear
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            flags_low_q <= pif_pkg::FLAGS_RESET;
            flags_high_q <= pif_pkg::FLAGS_RESET;
        end else begin
            // bit writes arrive as read-modify-write bytes from the core
            if (wr_low) begin
                flags_low_q <= (wdata_i | set_vec[7:0]) & pif_pkg::LOW_USED;
            end else begin
                flags_low_q <= ((flags_low_q & ~clr_vec[7:0]) | set_vec[7:0])
                    & pif_pkg::LOW_USED;
            end
            if (wr_high) begin
                flags_high_q <= {wdata_i[7] | set_vec[7], 6'h00,
                    wdata_i[0] | set_vec[8]};
            end else begin
                flags_high_q <= {(flags_high_q[7] & ~clr_vec[7]) | set_vec[7], 6'h00,
                    (flags_high_q[0] & ~clr_vec[8]) | set_vec[8]};
            end
        end
    end

    // masks: unused bits stay 1 so they never enable anything
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mask_low_q <= pif_pkg::MASK_RESET;
            mask_high_q <= pif_pkg::MASK_RESET;
        end else begin
            if (wr_i && addr_i == pif_pkg::ADDR_MASK_LOW) begin
                mask_low_q <= wdata_i | ~pif_pkg::LOW_USED;
            end
            if (wr_i && addr_i == pif_pkg::ADDR_MASK_HIGH) begin
                mask_high_q <= wdata_i | ~pif_pkg::HIGH_USED;
            end
        end
    end

    // nmi pending latch; cleared when the core takes it
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            nmi_pend_q <= 1'b0;
        end else if (ev_rise[0] && mode_sync_q[1]) begin
            nmi_pend_q <= 1'b1;
        end else if (state_q == pif_pkg::PIF_IDLE && ack_i && taken_q.nmi) begin
            nmi_pend_q <= 1'b0;
        end
    end

    // global enable: software write, cleared when acknowledge starts
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ie_q <= 1'b0;
        end else if (state_q == pif_pkg::PIF_IDLE && ack_i && taken_q.valid) begin
            ie_q <= 1'b0;
        end else if (wr_ctrl) begin
            ie_q <= wdata_i[pif_pkg::CTRL_BIT_IE];
        end
    end

    // registered request toward the core
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            taken_q <= '0;
            standby_release_o <= 1'b0;
        end else begin
            standby_release_o <= nmi_pend_q || win_valid;
            if (state_q != pif_pkg::PIF_IDLE || (ack_i && taken_q.valid)) begin
                taken_q <= '0;
            end else if (nmi_pend_q) begin
                taken_q <= '{valid: 1'b1, nmi: 1'b1, level: 4'h0,
                    vector: pif_pkg::VEC_NMI};
            end else if (win_valid && ie_q) begin
                taken_q <= '{valid: 1'b1, nmi: 1'b0, level: win_idx,
                    vector: win_vec};
            end else begin
                taken_q <= '0;
            end
        end
    end
    assign req_o = taken_q;
    assign global_interrupt_enable_o = ie_q;

    // acknowledge sequence: push status, push pc, load vector
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= pif_pkg::PIF_IDLE;
            push_psw_o <= 1'b0;
            push_pc_o <= 1'b0;
            load_pc_o <= 1'b0;
            vector_o <= 16'h0000;
        end else begin
            push_psw_o <= 1'b0;
            push_pc_o <= 1'b0;
            load_pc_o <= 1'b0;
            case (state_q)
                pif_pkg::PIF_IDLE: begin
                    if (ack_i && taken_q.valid) begin
                        state_q <= pif_pkg::PIF_PUSH_PSW;
                        push_psw_o <= 1'b1;
                        vector_o <= taken_q.vector;
                    end
                end
                pif_pkg::PIF_PUSH_PSW: begin
                    state_q <= pif_pkg::PIF_PUSH_PC;
                    push_pc_o <= 1'b1;
                end
                pif_pkg::PIF_PUSH_PC: begin
                    state_q <= pif_pkg::PIF_VECTOR;
                    load_pc_o <= 1'b1;
                end
                default: begin
                    state_q <= pif_pkg::PIF_IDLE;
                end
            endcase
        end
    end

    // read mux, data valid one cycle after the strobe
    always_comb begin
        if (addr_i == pif_pkg::ADDR_FLAGS_LOW) begin
            rd_d = flags_low_q;
        end else if (addr_i == pif_pkg::ADDR_FLAGS_HIGH) begin
            rd_d = flags_high_q;
        end else if (addr_i == pif_pkg::ADDR_MASK_LOW) begin
            rd_d = mask_low_q;
        end else if (addr_i == pif_pkg::ADDR_MASK_HIGH) begin
            rd_d = mask_high_q;
        end else if (addr_i == pif_pkg::ADDR_CONTROL) begin
            rd_d = {6'h00, mode_sync_q[1], ie_q};
        end else if (addr_i == pif_pkg::ADDR_STATUS) begin
            rd_d = {win_valid, nmi_pend_q, 2'h0, win_idx};
        end else begin
            rd_d = 8'h00;
        end
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= 8'h00;
        end else begin
            rdata_o <= rd_i ? rd_d : 8'h00;
        end
    end

    // a maskable request was flagged, unmasked and enabled when it was latched
    chk_mask_gate_req: assert property (@(posedge clk_i) disable iff (rst_i)
        taken_q.valid && !taken_q.nmi |-> $past(ie_q)
        && ((($past(ready_vec) >> taken_q.level) & 9'h001) == 9'h001))
        else $error("maskable request issued while masked or disabled");
    chk_nmi_wins: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(nmi_pend_q) && $past(state_q) == pif_pkg::PIF_IDLE && !$past(ack_i)
        |-> taken_q.nmi)
        else $error("nmi lost arbitration");
    // acknowledge walk: the trigger, then three one-cycle pulses
    sequence seq_ack;
        state_q == pif_pkg::PIF_IDLE && ack_i && taken_q.valid;
    endsequence
    sequence seq_push;
        push_psw_o && !ie_q ##1 push_pc_o ##1 load_pc_o;
    endsequence
    chk_ack_order: assert property (@(posedge clk_i) disable iff (rst_i)
        seq_ack |=> seq_push)
        else $error("acknowledge sequence out of order");
    chk_ack_vector: assert property (@(posedge clk_i) disable iff (rst_i)
        seq_ack |=> vector_o == $past(taken_q.vector))
        else $error("vector output differs from taken request");
    chk_req_drop: assert property (@(posedge clk_i) disable iff (rst_i)
        seq_ack |=> !taken_q.valid)
        else $error("request still shown after acknowledge");
    // a fresh event or a write may legally re-set the flag, so those cycles are skipped
    chk_ack_clears: assert property (@(posedge clk_i) disable iff (rst_i)
        seq_ack ##0 (!taken_q.nmi && !wr_i && set_vec == '0)
        |=> ((flag_vec >> $past(taken_q.level)) & 9'h001) == 9'h000)
        else $error("acknowledged flag not cleared");
    chk_release_any: assert property (@(posedge clk_i) disable iff (rst_i)
        nmi_pend_q || win_valid |=> standby_release_o)
        else $error("standby release missing");
    chk_fixed_prio: assert property (@(posedge clk_i) disable iff (rst_i)
        win_valid |-> ((flag_vec & ~mask_vec) & ((9'h001 << win_idx) - 9'h001)) == 9'h000)
        else $error("lower priority line picked");
    chk_unused_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        flags_low_q[7] == 1'b0 && flags_high_q[6:1] == 6'h00)
        else $error("reserved flag bit set");
    chk_mask_reserved: assert property (@(posedge clk_i) disable iff (rst_i)
        mask_low_q[7] && mask_high_q[6:1] == 6'h3F)
        else $error("reserved mask bit cleared");
    chk_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
        set_vec[1] |=> flags_low_q[1])
        else $error("event flag not set");
    // watchdog overflow takes exactly one path, picked by the synced mode
    chk_nmi_latch: assert property (@(posedge clk_i) disable iff (rst_i)
        ev_rise[0] && mode_sync_q[1] |=> nmi_pend_q)
        else $error("watchdog overflow in mode 1 not latched");
    chk_wdt_maskable: assert property (@(posedge clk_i) disable iff (rst_i)
        ev_rise[0] && !mode_sync_q[1] |=> flags_low_q[0])
        else $error("interval overflow did not set its flag");
    // two serial events share one flag; the three-wire event must set it
    chk_serial_merge: assert property (@(posedge clk_i) disable iff (rst_i)
        ev_rise[5] |=> flags_low_q[4])
        else $error("three-wire event did not set shared flag");
    chk_word_timer: assert property (@(posedge clk_i) disable iff (rst_i)
        set_vec[7] |=> flags_high_q[7])
        else $error("word timer flag not set");
    chk_key_lowest: assert property (@(posedge clk_i) disable iff (rst_i)
        win_valid && win_idx == 4'h8 |-> ready_vec[7:0] == 8'h00)
        else $error("key return picked over a higher line");
    chk_vec_pin1: assert property (@(posedge clk_i) disable iff (rst_i)
        taken_q.valid && !taken_q.nmi && taken_q.level == 4'h2
        |-> taken_q.vector == pif_pkg::VEC_PIN1)
        else $error("second pin edge vector wrong");
    // read data must not linger past its one cycle
    chk_rdata_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        !rd_i |=> rdata_o == 8'h00)
        else $error("read data shown without a read");
endmodule // pif_top

/* sim/pif_core_model.sv */
// behavioural core that acknowledges requests presented by the flag block
`timescale 1ns/1ps
module pif_core_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic req_valid_i,
    input wire logic [3:0] delay_i,
    output logic ack_o
);
    logic [3:0] cnt_q;
    logic ack_q;
    // acknowledge a presented request after delay_i waiting cycles, one cycle long
    // a one-cycle pulse keeps a stale ack from taking the next request by accident
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= 4'h0;
            ack_q <= 1'b0;
        end else begin
            ack_q <= 1'b0;
            if (req_valid_i && !ack_q) begin
                if (cnt_q == delay_i) begin
                    ack_q <= 1'b1;
                    cnt_q <= 4'h0;
                end else begin
                    cnt_q <= cnt_q + 4'h1;
                end
            end else begin
                cnt_q <= 4'h0;
            end
        end
    end
    assign ack_o = ack_q;
endmodule // pif_core_model

/* sim/prioritized_interrupt_flags_test.sv */
// self-checking bench for the prioritized interrupt flag block
`timescale 1ns/1ps
module prioritized_interrupt_flags_test;
    localparam logic [15:0] VT [9] = '{16'h0004, 16'h0006, 16'h0008, 16'h000A,
        16'h000C, 16'h000E, 16'h0010, 16'h0014, 16'h002A};
    localparam logic [15:0] RA [5] = '{16'hFFE0, 16'hFFE1, 16'hFFE4, 16'hFFE5, 16'h1234};
    localparam logic [7:0] RV [5] = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00};
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [9:0] ev = 10'h000;
    logic wdm1 = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [3:0] ack_delay = 4'h0;
    logic ack, stby, processor_status_word, pc, ld, ie;
    logic [7:0] rdata, d, dh;
    logic [15:0] vec;
    logic [15:0] lfsr = 16'h6D1F;
    pif_pkg::pif_req_t req, r;
    int error_cnt = 0;
    int total_checks = 0;
    // 50 ns period clock
    initial begin
        forever #25 clk_i = ~clk_i;
    end
    pif_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .watchdog_overflow_request_i(ev[0]),
        .watchdog_mode1_i(wdm1), .pin_edge_request_0_i(ev[1]), .pin_edge_request_1_i(ev[2]),
        .pin_edge_request_2_i(ev[3]), .serial_receive_done_request_i(ev[4]),
        .three_wire_done_request_i(ev[5]), .serial_transmit_done_request_i(ev[6]),
        .byte_timer_match_request_i(ev[7]), .word_timer_match_request_i(ev[8]),
        .key_return_request_i(ev[9]), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
        .rd_i(rd), .rdata_o(rdata), .ack_i(ack), .req_o(req), .standby_release_o(stby),
        .push_psw_o(processor_status_word), .push_pc_o(pc), .load_pc_o(ld), .vector_o(vec),
        .global_interrupt_enable_o(ie));
    pif_core_model u_core (.clk_i(clk_i), .rst_i(rst_i), .req_valid_i(req.valid),
        .delay_i(ack_delay), .ack_o(ack));
    // sixteen-bit maximal-length shift sequence
    function automatic logic [15:0] lfsr_next(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    // {high, low} flag bit that one event line should set
    function automatic logic [15:0] exp_flag(input int j);
        case (j)
            0, 1, 2, 3, 4: return 16'h0001 << j;
            5: return 16'h0010;
            6: return 16'h0020;
            7: return 16'h0040;
            8: return 16'h8000;
            default: return 16'h0100;
        endcase
    endfunction
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic timeout();
        error_cnt++;
        $display("FAIL t=%0t got=%h exp=%h wait ran out", $time, 1'b0, 1'b1);
        results();
    endtask
    task automatic bus_wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge clk_i);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk_i);
        wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic bus_rd(input logic [15:0] a, output logic [7:0] v);
        @(posedge clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_i);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic pulse(input int j);
        @(posedge clk_i);
        ev[j] <= 1'b1;
        repeat (2) @(posedge clk_i);
        ev[j] <= 1'b0;
    endtask
    task automatic wait_req(output pif_pkg::pif_req_t q);
        int n;
        // step off the edge so the registered request has settled
        #1;
        for (n = 0; n < 60 && req.valid !== 1'b1; n++) begin
            @(posedge clk_i);
            #1;
        end
        if (n == 60)
            timeout();
        q = req;
    endtask
    // status push, pc push, then vector load on consecutive cycles
    task automatic wait_seq(input logic [15:0] v);
        int n;
        for (n = 0; n < 30 && processor_status_word !== 1'b1; n++) begin
            @(posedge clk_i);
            #1;
        end
        if (n == 30)
            timeout();
        chk({15'h0000, ie}, 16'h0000);
        @(posedge clk_i);
        #1 chk({15'h0000, pc}, 16'h0001);
        @(posedge clk_i);
        #1 chk({15'h0000, ld}, 16'h0001);
        chk(vec, v);
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            bus_rd(RA[i], d);
            chk({8'h00, d}, {8'h00, RV[i]});
        end
        $display("test reset values done");
        // random bytes; unused bits must read back zero
        for (int k = 0; k < 6; k++) begin
            lfsr = lfsr_next(lfsr);
            bus_wr(16'hFFE0, lfsr[7:0]);
            bus_wr(16'hFFE1, lfsr[15:8]);
            bus_rd(16'hFFE0, d);
            bus_rd(16'hFFE1, dh);
            chk({dh, d}, lfsr & 16'h817F);
            chk({15'h0000, stby}, 16'h0000);
        end
        bus_wr(16'hFFE0, 8'h00);
        bus_wr(16'hFFE1, 8'h00);
        $display("test flag access done");
        for (int j = 0; j < 10; j++) begin
            pulse(j);
            repeat (4) @(posedge clk_i);
            bus_rd(16'hFFE0, d);
            bus_rd(16'hFFE1, dh);
            chk({dh, d}, exp_flag(j));
            bus_wr(16'hFFE0, 8'h00);
            bus_wr(16'hFFE1, 8'h00);
        end
        $display("test event flags done");
        // all pending: blocked first by masks, then by the global enable
        bus_wr(16'hFFE0, 8'h7F);
        bus_wr(16'hFFE1, 8'h81);
        bus_wr(16'hFFE8, 8'h01);
        repeat (6) @(posedge clk_i);
        #1 chk({15'h0000, req.valid}, 16'h0000);
        bus_wr(16'hFFE8, 8'h00);
        bus_wr(16'hFFE4, 8'h00);
        bus_wr(16'hFFE5, 8'h00);
        repeat (6) @(posedge clk_i);
        #1 chk({15'h0000, req.valid}, 16'h0000);
        chk({15'h0000, stby}, 16'h0001);
        bus_rd(16'hFFE9, d);
        chk({8'h00, d}, 16'h0080);
        for (int p = 0; p < 9; p++) begin
            bus_wr(16'hFFE8, 8'h01);
            wait_req(r);
            chk({12'h000, r.level}, 16'(p));
            chk(r.vector, VT[p]);
            wait_seq(VT[p]);
        end
        bus_rd(16'hFFE0, d);
        bus_rd(16'hFFE1, dh);
        chk({dh, d}, 16'h0000);
        $display("test priority order done");
        // pending unmasked flag with enable off; the watchdog must still win
        bus_wr(16'hFFE0, 8'h02);
        @(posedge clk_i);
        wdm1 <= 1'b1;
        ack_delay <= 4'h3;
        repeat (4) @(posedge clk_i);
        bus_rd(16'hFFE8, d);
        chk({8'h00, d}, 16'h0002);
        pulse(0);
        wait_req(r);
        chk({15'h0000, r.nmi}, 16'h0001);
        chk(r.vector, 16'h0004);
        chk({15'h0000, stby}, 16'h0001);
        wait_seq(16'h0004);
        bus_rd(16'hFFE0, d);
        chk({8'h00, d}, 16'h0002);
        $display("test non-maskable done");
        results();
    end
endmodule // prioritized_interrupt_flags_test
